// ==== include/flk_pkg.sv ====
package flk_pkg;

  // Self-program control register fields
  localparam int unsigned CTRL_EN_BIT    = 0;
  localparam int unsigned CTRL_ERASE_BIT = 1;
  localparam int unsigned CTRL_WRITE_BIT = 2;
  localparam int unsigned CTRL_LOCK_BIT  = 3;
  localparam int unsigned CTRL_RWW_BIT   = 4;
  localparam int unsigned CTRL_BUSY_BIT  = 6;
  localparam logic [7:0]  CTRL_WMASK     = 8'h1f;
  localparam logic [7:0]  CTRL_RST       = 8'h00;

  // Pointer values selecting a configuration byte
  localparam logic [15:0] Z_FUSE_LO = 16'h0000;
  localparam logic [15:0] Z_LOCK    = 16'h0001;
  localparam logic [15:0] Z_FUSE_EX = 16'h0002;
  localparam logic [15:0] Z_FUSE_HI = 16'h0003;

  // Lock byte: boot protection bits
  localparam int unsigned LOCK_BOOT_LO_BIT = 4;
  localparam int unsigned LOCK_BOOT_HI_BIT = 5;
  localparam logic [7:0]  LOCK_RST         = 8'hff;
  localparam logic [3:0]  FUSE_EX_UNDEF    = 4'hf;

  // Fuse masks, 1 = programmed
  localparam logic [7:0] FUSE_LO_RST = 8'h00;
  localparam logic [7:0] FUSE_HI_RST = 8'h00;
  localparam logic [3:0] FUSE_EX_RST = 4'h0;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_FUSE_LO = 8'h04;
  localparam logic [7:0] OFS_FUSE_HI = 8'h08;
  localparam logic [7:0] OFS_FUSE_EX = 8'h0c;
  localparam logic [7:0] OFS_STATUS  = 8'h10;
  localparam logic [7:0] OFS_LOCK    = 8'h14;
  localparam int unsigned STAT_BUSY_BIT   = 0;
  localparam int unsigned STAT_REFUSE_BIT = 1;
  localparam int unsigned STAT_BLOCK_BIT  = 2;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Timing windows in CPU cycles
  localparam logic [2:0] SPM_WIN_CYC = 3'd4;
  localparam logic [2:0] LPM_WIN_CYC = 3'd3;

  // Programming time, microseconds, and the RC oscillator rate
  localparam int unsigned PROG_MIN_US = 3700;
  localparam int unsigned PROG_MAX_US = 4500;
  localparam int unsigned RC_FREQ_KHZ = 8000;
  // One extra tick covers the partial first oscillator period
  localparam int unsigned PROG_TICKS  = (PROG_MIN_US * RC_FREQ_KHZ + 999) / 1000 + 1;

  localparam logic [14:0] BOOT_START_WORD = 15'h0f80;

  typedef enum logic [1:0] {
    OP_ERASE = 2'b00,
    OP_WRITE = 2'b01,
    OP_LOCK  = 2'b11
  } flk_op_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_FIN  = 2'b11
  } flk_prog_state_type;

endpackage

// ==== rtl/flk_prog_timer.sv ====
`timescale 1ns/1ps
module flk_prog_timer #(
  parameter int unsigned TICKS = flk_pkg::PROG_TICKS
) (
  input  wire logic       i_clk,
  input  wire logic       i_por_n,
  input  wire logic       i_rc_tick,
  input  wire logic       i_start,
  input  wire logic [1:0] i_op,
  input  wire logic [7:0] i_lock_data,
  output logic            o_busy,
  output logic            o_done,
  output logic [7:0]      o_lock
);

  localparam int unsigned CW = $clog2(TICKS + 1);

  typedef struct packed {
    flk_pkg::flk_prog_state_type st;
    flk_pkg::flk_op_type         op;
    logic [CW-1:0]               cnt;
    logic [7:0]                  lock_data;
    logic [7:0]                  lock;
  } flk_tmr_state_type;

  localparam flk_tmr_state_type S_RST = '{
    st: flk_pkg::ST_IDLE, op: flk_pkg::OP_ERASE, cnt: '0,
    lock_data: 8'hff, lock: flk_pkg::LOCK_RST};

  flk_tmr_state_type s_r;
  flk_tmr_state_type s_nxt;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt = s_r;
    unique case (s_r.st)
      flk_pkg::ST_IDLE: begin
        if (i_start) begin
          s_nxt.st        = flk_pkg::ST_RUN;
          s_nxt.op        = flk_pkg::flk_op_type'(i_op);
          s_nxt.lock_data = i_lock_data;
          s_nxt.cnt       = '0;
        end
      end
      flk_pkg::ST_RUN: begin
        if (i_rc_tick) begin
          if (s_r.cnt == CW'(TICKS - 1)) begin
            s_nxt.st = flk_pkg::ST_FIN;
          end else begin
            s_nxt.cnt = s_r.cnt + CW'(1);
          end
        end
      end
      flk_pkg::ST_FIN: begin
        // Lock bits only move toward programmed
        if (s_r.op == flk_pkg::OP_LOCK) begin
          s_nxt.lock = s_r.lock & {2'b11, s_r.lock_data[5:2], 2'b11};
        end
        s_nxt.st = flk_pkg::ST_IDLE;
      end
      default: s_nxt.st = flk_pkg::ST_IDLE;
    endcase
  end

  // Power-on reset only, so a CPU reset cannot cut a write short
  always_ff @(posedge i_clk or negedge i_por_n) begin
    if (!i_por_n) begin
      s_r <= S_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_busy = (s_r.st != flk_pkg::ST_IDLE);
  assign o_done = (s_r.st == flk_pkg::ST_FIN);
  assign o_lock = s_r.lock;

endmodule

// ==== rtl/flk_top.sv ====
// What this block does
// - A program-memory load within three cycles of both lock-set and enable bits returns a config byte.
// - Pointer 2 returns the extended fuse byte in bits 3..0, upper bits undefined.
// - Programmed fuse and lock bits read as 0 on a program-memory load, unprogrammed ones as 1; the bus fuse registers hold 1 = programmed.
// - A CPU reset (I_RST_N) during a flash write does not abort that write; power-on reset (I_POR_N) does.
// - Flash programming time is counted on the calibrated RC oscillator, not the CPU clock.
// - Erase, page write and lock write last between 3.7 ms and 4.5 ms.
// - Programmed boot lock bits refuse self-programming of the boot section.
// - Lock bits are written from working register zero by pattern X0001001 and a store within four cycles.
`timescale 1ns/1ps
module flk_top #(
  parameter int unsigned PROG_TICKS = flk_pkg::PROG_TICKS,
  parameter logic [14:0] BOOT_START = flk_pkg::BOOT_START_WORD
) (
  input  wire logic        I_CLK,
  input  wire logic        I_RST_N,
  input  wire logic        I_POR_N,
  input  wire logic        I_RC_TICK,
  input  wire logic        I_CTRL_WE,
  input  wire logic [7:0]  I_CTRL_WDATA,
  input  wire logic        I_LPM,
  input  wire logic        I_SPM,
  input  wire logic [15:0] I_Z,
  input  wire logic [7:0]  I_WORKING_REG_ZERO,
  input  wire logic [7:0]  I_FLASH_DATA,
  output logic      [7:0]  O_CTRL,
  output logic             O_LPM_VALID,
  output logic             O_LPM_CFG,
  output logic      [7:0]  O_LPM_DATA,
  output logic             O_BUSY,
  output logic             O_PROG_DONE,
  input  wire logic [7:0]  I_S_AXI_AWADDR,
  input  wire logic        I_S_AXI_AWVALID,
  output logic             O_S_AXI_AWREADY,
  input  wire logic [31:0] I_S_AXI_WDATA,
  input  wire logic [3:0]  I_S_AXI_WSTRB,
  input  wire logic        I_S_AXI_WVALID,
  output logic             O_S_AXI_WREADY,
  output logic      [1:0]  O_S_AXI_BRESP,
  output logic             O_S_AXI_BVALID,
  input  wire logic        I_S_AXI_BREADY,
  input  wire logic [7:0]  I_S_AXI_ARADDR,
  input  wire logic        I_S_AXI_ARVALID,
  output logic             O_S_AXI_ARREADY,
  output logic      [31:0] O_S_AXI_RDATA,
  output logic      [1:0]  O_S_AXI_RRESP,
  output logic             O_S_AXI_RVALID,
  input  wire logic        I_S_AXI_RREADY
);

  typedef struct packed {
    logic [7:0]  ctrl;
    logic [2:0]  win;
    logic        lpm_vld;
    logic        lpm_cfg;
    logic [7:0]  lpm_dat;
    logic        refused;
    logic [7:0]  fuse_lo;
    logic [7:0]  fuse_hi;
    logic [3:0]  fuse_ex;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic        wstrb0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } flk_top_state_type;

  localparam flk_top_state_type S_RST = '{
    ctrl: flk_pkg::CTRL_RST, win: 3'd0, lpm_vld: 1'b0, lpm_cfg: 1'b0,
    lpm_dat: 8'h00, refused: 1'b0, fuse_lo: flk_pkg::FUSE_LO_RST,
    fuse_hi: flk_pkg::FUSE_HI_RST, fuse_ex: flk_pkg::FUSE_EX_RST,
    aw_got: 1'b0, w_got: 1'b0, awaddr: 8'h00, wdata: 32'h0000_0000,
    wstrb0: 1'b0, bvalid: 1'b0, bresp: flk_pkg::RESP_OKAY, rvalid: 1'b0,
    rdata: 32'h0000_0000, rresp: flk_pkg::RESP_OKAY};

  flk_top_state_type s_r;
  flk_top_state_type s_nxt;

  logic       busy;
  logic       done;
  logic [7:0] lock;
  logic       start;
  logic [1:0] start_op;
  logic       boot_locked;
  logic [7:0] ctrl_rd;

  ////////////////////////////////////////////////////////////////////////////////
  flk_prog_timer #(
    .TICKS (PROG_TICKS)
  ) u_timer (
    .i_clk       (I_CLK),
    .i_por_n     (I_POR_N),
    .i_rc_tick   (I_RC_TICK),
    .i_start     (start),
    .i_op        (start_op),
    .i_lock_data (I_WORKING_REG_ZERO),
    .o_busy      (busy),
    .o_done      (done),
    .o_lock      (lock)
  );

  assign boot_locked = !(lock[flk_pkg::LOCK_BOOT_LO_BIT] & lock[flk_pkg::LOCK_BOOT_HI_BIT]);
  assign ctrl_rd     = s_r.ctrl | (busy ? (8'h01 << flk_pkg::CTRL_BUSY_BIT) : 8'h00);

  // Config byte for a pointer value; fuses are held as programmed masks
  function automatic logic [7:0] cfg_byte(input logic [15:0] z, input logic [7:0] flo,
                                          input logic [7:0] fhi, input logic [3:0] fex,
                                          input logic [7:0] lk);
    logic [7:0] b;
    b = 8'hff;
    unique case (z)
      flk_pkg::Z_FUSE_LO: b = ~flo;
      flk_pkg::Z_LOCK:    b = lk;
      flk_pkg::Z_FUSE_EX: b = {flk_pkg::FUSE_EX_UNDEF, ~fex};
      flk_pkg::Z_FUSE_HI: b = ~fhi;
      default:            b = 8'hff;
    endcase
    return b;
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= flk_pkg::OFS_LOCK);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic       axi_wr;
    logic       wr_ctrl;
    logic [7:0] wr_val;
    logic       refuse_set;
    axi_wr     = 1'b0;
    wr_ctrl    = 1'b0;
    wr_val     = 8'h00;
    refuse_set = 1'b0;
    start      = 1'b0;
    start_op   = flk_pkg::OP_ERASE;
    s_nxt      = s_r;
    s_nxt.lpm_vld = 1'b0;
    s_nxt.lpm_cfg = 1'b0;

    // Write address and data, taken in either order
    if (I_S_AXI_AWVALID && O_S_AXI_AWREADY) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = I_S_AXI_AWADDR;
    end
    if (I_S_AXI_WVALID && O_S_AXI_WREADY) begin
      s_nxt.w_got  = 1'b1;
      s_nxt.wdata  = I_S_AXI_WDATA;
      s_nxt.wstrb0 = I_S_AXI_WSTRB[0];
    end
    if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
      axi_wr       = 1'b1;
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got  = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = addr_ok(s_r.awaddr) ? flk_pkg::RESP_OKAY : flk_pkg::RESP_SLVERR;
    end
    if (s_r.bvalid && I_S_AXI_BREADY) begin
      s_nxt.bvalid = 1'b0;
    end

    if (axi_wr && s_r.wstrb0) begin
      unique case (s_r.awaddr)
        flk_pkg::OFS_CTRL: begin
          wr_ctrl = 1'b1;
          wr_val  = s_r.wdata[7:0];
        end
        flk_pkg::OFS_FUSE_LO: s_nxt.fuse_lo = s_r.wdata[7:0];
        flk_pkg::OFS_FUSE_HI: s_nxt.fuse_hi = s_r.wdata[7:0];
        flk_pkg::OFS_FUSE_EX: s_nxt.fuse_ex = s_r.wdata[3:0];
        flk_pkg::OFS_STATUS: begin
          if (s_r.wdata[flk_pkg::STAT_REFUSE_BIT]) begin
            s_nxt.refused = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // CPU store to the control register wins over a bus write
    if (I_CTRL_WE) begin
      wr_ctrl = 1'b1;
      wr_val  = I_CTRL_WDATA;
    end

    // Control register and the timed window
    if (wr_ctrl && !busy) begin
      s_nxt.ctrl = wr_val & flk_pkg::CTRL_WMASK;
      s_nxt.win  = flk_pkg::SPM_WIN_CYC;
    end else if (s_r.win != 3'd0) begin
      s_nxt.win = s_r.win - 3'd1;
      if (s_r.win == 3'd1 && !busy) begin
        s_nxt.ctrl = flk_pkg::CTRL_RST;
      end
    end

    // Program-memory load
    if (I_LPM) begin
      s_nxt.lpm_vld = 1'b1;
      s_nxt.lpm_dat = I_FLASH_DATA;
      if (s_r.win > (flk_pkg::SPM_WIN_CYC - flk_pkg::LPM_WIN_CYC)
          && s_r.ctrl[flk_pkg::CTRL_LOCK_BIT] && s_r.ctrl[flk_pkg::CTRL_EN_BIT]) begin
        s_nxt.lpm_cfg = 1'b1;
        s_nxt.lpm_dat = cfg_byte(I_Z, s_r.fuse_lo, s_r.fuse_hi, s_r.fuse_ex, lock);
        s_nxt.ctrl    = flk_pkg::CTRL_RST;
        s_nxt.win     = 3'd0;
      end
    end

    // Store instruction inside the window
    if (I_SPM && s_r.win != 3'd0 && s_r.ctrl[flk_pkg::CTRL_EN_BIT] && !busy) begin
      s_nxt.win = 3'd0;
      if (s_r.ctrl[flk_pkg::CTRL_LOCK_BIT]) begin
        start    = 1'b1;
        start_op = flk_pkg::OP_LOCK;
      end else if (s_r.ctrl[flk_pkg::CTRL_ERASE_BIT] || s_r.ctrl[flk_pkg::CTRL_WRITE_BIT]) begin
        if (boot_locked && I_Z[15:1] >= BOOT_START) begin
          refuse_set = 1'b1;
          s_nxt.ctrl = flk_pkg::CTRL_RST;
        end else begin
          start    = 1'b1;
          start_op = s_r.ctrl[flk_pkg::CTRL_ERASE_BIT] ? flk_pkg::OP_ERASE : flk_pkg::OP_WRITE;
        end
      end else begin
        // Buffer fill or RWW re-enable: no timed access
        s_nxt.ctrl = flk_pkg::CTRL_RST;
      end
    end
    if (done) begin
      s_nxt.ctrl = flk_pkg::CTRL_RST;
    end
    if (refuse_set) begin
      s_nxt.refused = 1'b1;
    end

    // Register reads
    if (I_S_AXI_ARVALID && O_S_AXI_ARREADY) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = addr_ok(I_S_AXI_ARADDR) ? flk_pkg::RESP_OKAY : flk_pkg::RESP_SLVERR;
      unique case (I_S_AXI_ARADDR)
        flk_pkg::OFS_CTRL:    s_nxt.rdata = {24'h000000, ctrl_rd};
        flk_pkg::OFS_FUSE_LO: s_nxt.rdata = {24'h000000, s_r.fuse_lo};
        flk_pkg::OFS_FUSE_HI: s_nxt.rdata = {24'h000000, s_r.fuse_hi};
        flk_pkg::OFS_FUSE_EX: s_nxt.rdata = {28'h0000000, s_r.fuse_ex};
        flk_pkg::OFS_STATUS:  s_nxt.rdata = {29'h00000000, boot_locked, s_r.refused, busy};
        flk_pkg::OFS_LOCK:    s_nxt.rdata = {24'h000000, lock};
        default:              s_nxt.rdata = 32'h0000_0000;
      endcase
    end else if (s_r.rvalid && I_S_AXI_RREADY) begin
      s_nxt.rvalid = 1'b0;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      s_r <= S_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  assign O_CTRL          = ctrl_rd;
  assign O_LPM_VALID     = s_r.lpm_vld;
  assign O_LPM_CFG       = s_r.lpm_cfg;
  assign O_LPM_DATA      = s_r.lpm_dat;
  assign O_BUSY          = busy;
  assign O_PROG_DONE     = done;
  assign O_S_AXI_AWREADY = !s_r.aw_got && !s_r.bvalid;
  assign O_S_AXI_WREADY  = !s_r.w_got && !s_r.bvalid;
  assign O_S_AXI_BVALID  = s_r.bvalid;
  assign O_S_AXI_BRESP   = s_r.bresp;
  assign O_S_AXI_ARREADY = !s_r.rvalid;
  assign O_S_AXI_RVALID  = s_r.rvalid;
  assign O_S_AXI_RDATA   = s_r.rdata;
  assign O_S_AXI_RRESP   = s_r.rresp;

endmodule

// ==== tb/flk_top_sva.sv ====
`timescale 1ns/1ps
module flk_top_sva #(
  parameter int unsigned PROG_TICKS = flk_pkg::PROG_TICKS
) (
  input wire logic        I_CLK,
  input wire logic        I_RST_N,
  input wire logic        I_POR_N,
  input wire logic        I_RC_TICK,
  input wire logic        I_CTRL_WE,
  input wire logic [7:0]  I_CTRL_WDATA,
  input wire logic        I_LPM,
  input wire logic        I_SPM,
  input wire logic [15:0] I_Z,
  input wire logic [7:0]  I_WORKING_REG_ZERO,
  input wire logic [7:0]  O_CTRL,
  input wire logic        O_LPM_VALID,
  input wire logic        O_LPM_CFG,
  input wire logic [7:0]  O_LPM_DATA,
  input wire logic        O_BUSY,
  input wire logic        O_PROG_DONE
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  logic [15:0] ticks_r;
  logic        boot_lk_r;
  // Oscillator ticks seen while busy; boot lock seen in store data
  always_ff @(posedge I_CLK or negedge I_POR_N) begin
    if (!I_POR_N) begin
      ticks_r   <= 16'h0000;
      boot_lk_r <= 1'b0;
    end else begin
      ticks_r   <= O_BUSY ? ticks_r + {15'h0000, I_RC_TICK} : 16'h0000;
      boot_lk_r <= boot_lk_r || (I_SPM && O_CTRL[0] && O_CTRL[3]
                   && I_WORKING_REG_ZERO[5:4] == 2'b00);
    end
  end
  ////////////////////////////////////////////////////////////////
  sequence s_arm;
    I_CTRL_WE && I_CTRL_WDATA[3] && I_CTRL_WDATA[0] && !O_BUSY;
  endsequence
  sequence s_quiet;
    !I_CTRL_WE && !I_LPM && !I_SPM;
  endsequence
  property p_lpm_valid;
    I_LPM |=> O_LPM_VALID;
  endproperty
  a_lpm_valid: assert property (p_lpm_valid) else $error("load without result");
  property p_cfg_win;
    s_arm ##1 s_quiet ##1 s_quiet ##1 I_LPM |=> O_LPM_CFG;
  endproperty
  a_cfg_win: assert property (p_cfg_win) else $error("late cfg load lost");
  property p_cfg_late;
    s_arm ##1 s_quiet[*3] ##1 I_LPM |=> O_LPM_VALID && !O_LPM_CFG;
  endproperty
  a_cfg_late: assert property (p_cfg_late) else $error("cfg after window");
  property p_ext_hi;
    O_LPM_CFG && $past(I_Z) == flk_pkg::Z_FUSE_EX |-> O_LPM_DATA[7:4] == flk_pkg::FUSE_EX_UNDEF;
  endproperty
  a_ext_hi: assert property (p_ext_hi) else $error("ext fuse upper bits");
  property p_ctrl_clr;
    s_arm ##1 s_quiet[*4] |=> O_CTRL[3:0] == 4'h0;
  endproperty
  a_ctrl_clr: assert property (p_ctrl_clr) else $error("control kept after window");
  property p_lock_go;
    I_SPM && O_CTRL[0] && O_CTRL[3] && !O_BUSY |=> O_BUSY;
  endproperty
  a_lock_go: assert property (p_lock_go) else $error("lock write not started");
  property p_refuse;
    I_SPM && O_CTRL[0] && |O_CTRL[2:1] && !O_BUSY && boot_lk_r
      && I_Z[15:1] >= flk_pkg::BOOT_START_WORD |=> !O_BUSY ##1 !O_BUSY;
  endproperty
  a_refuse: assert property (p_refuse) else $error("boot update not refused");
  property p_rst_keep;
    disable iff (!I_POR_N) O_BUSY && !I_RST_N |=> O_BUSY || O_PROG_DONE;
  endproperty
  a_rst_keep: assert property (p_rst_keep) else $error("write aborted by reset");
  property p_ticks;
    disable iff (!I_POR_N)
      O_PROG_DONE |-> ticks_r + 1 >= PROG_TICKS && ticks_r <= PROG_TICKS + 1;
  endproperty
  a_ticks: assert property (p_ticks) else $error("duration not on oscillator");
  property p_done_end;
    disable iff (!I_POR_N) O_PROG_DONE |=> !O_BUSY;
  endproperty
  a_done_end: assert property (p_done_end) else $error("busy after done");
endmodule

bind flk_top flk_top_sva #(.PROG_TICKS(PROG_TICKS)) u_sva (.I_CLK, .I_RST_N, .I_POR_N,
  .I_RC_TICK, .I_CTRL_WE, .I_CTRL_WDATA, .I_LPM, .I_SPM, .I_Z, .I_WORKING_REG_ZERO,
  .O_CTRL, .O_LPM_VALID, .O_LPM_CFG, .O_LPM_DATA, .O_BUSY, .O_PROG_DONE);

// ==== tb/flk_cpu_model.sv ====
`timescale 1ns/1ps
module flk_cpu_model (
  input  wire logic        i_clk,
  output logic             o_ctrl_we,
  output logic      [7:0]  o_ctrl_wdata,
  output logic             o_lpm,
  output logic             o_spm,
  output logic      [15:0] o_z,
  output logic      [7:0]  o_r0
);
  initial begin
    o_ctrl_we = 1'b0;
    o_ctrl_wdata = 8'h00;
    o_lpm = 1'b0;
    o_spm = 1'b0;
    o_z = 16'h0000;
    o_r0 = 8'hff;
  end
  task automatic ctrl_wr(input logic [7:0] d);
    o_ctrl_we <= 1'b1;
    o_ctrl_wdata <= d;
    @(posedge i_clk);
    o_ctrl_we <= 1'b0;
  endtask
  task automatic load(input logic [15:0] a);
    o_lpm <= 1'b1;
    o_z <= a;
    @(posedge i_clk);
    o_lpm <= 1'b0;
  endtask
  task automatic store(input logic [15:0] a, input logic [7:0] d);
    o_spm <= 1'b1;
    o_z <= a;
    o_r0 <= d;
    @(posedge i_clk);
    o_spm <= 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge i_clk);
  endtask
endmodule

// ==== tb/fuse_lock_readback_and_spm_timing_bench.sv ====
`timescale 1ns/1ps
module fuse_lock_readback_and_spm_timing_bench;
  localparam int unsigned PT = 4;
  logic        clk, rst_n, por_n, tick, cwe, lpm, spm, lv, lcfg, busy, done;
  logic        awv, wv, bry, arv, rry, awr, wr, bv, arr, rv;
  logic [7:0]  cwd, r0, fdat, awa, ara, ctrl, ldat, flo, fhi, t;
  logic [3:0]  fex, ws;
  logic [2:0]  tdiv;
  logic [15:0] z;
  logic [31:0] wd, rdat;
  logic [1:0]  bresp, rresp;
  logic [7:0]  cfg [4];
  logic [8:0]  lq[$];
  logic [33:0] rq[$];
  int          mismatches, total_checks;

  flk_top #(.PROG_TICKS(PT)) u_dut (
    .I_CLK(clk), .I_RST_N(rst_n), .I_POR_N(por_n), .I_RC_TICK(tick),
    .I_CTRL_WE(cwe), .I_CTRL_WDATA(cwd), .I_LPM(lpm), .I_SPM(spm), .I_Z(z),
    .I_WORKING_REG_ZERO(r0), .I_FLASH_DATA(fdat), .O_CTRL(ctrl), .O_LPM_VALID(lv),
    .O_LPM_CFG(lcfg), .O_LPM_DATA(ldat), .O_BUSY(busy), .O_PROG_DONE(done),
    .I_S_AXI_AWADDR(awa), .I_S_AXI_AWVALID(awv), .O_S_AXI_AWREADY(awr),
    .I_S_AXI_WDATA(wd), .I_S_AXI_WSTRB(ws), .I_S_AXI_WVALID(wv), .O_S_AXI_WREADY(wr),
    .O_S_AXI_BRESP(bresp), .O_S_AXI_BVALID(bv), .I_S_AXI_BREADY(bry),
    .I_S_AXI_ARADDR(ara), .I_S_AXI_ARVALID(arv), .O_S_AXI_ARREADY(arr),
    .O_S_AXI_RDATA(rdat), .O_S_AXI_RRESP(rresp), .O_S_AXI_RVALID(rv),
    .I_S_AXI_RREADY(rry));
  flk_cpu_model u_cpu (.i_clk(clk), .o_ctrl_we(cwe), .o_ctrl_wdata(cwd), .o_lpm(lpm),
    .o_spm(spm), .o_z(z), .o_r0(r0));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Oscillator tick every fifth CPU cycle
  always @(posedge clk) begin
    tdiv <= (tdiv == 3'd4) ? 3'd0 : tdiv + 3'd1;
    tick <= (tdiv == 3'd4);
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [33:0] s, input logic [33:0] e);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e,
                     input logic [3:0] s = 4'hf);
    awa <= a;
    wd <= d;
    ws <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (!bv);
    bry <= 1'b0;
    chk("bresp", bresp, e);
    @(posedge clk);
  endtask
  task automatic axr(input logic [7:0] a, input logic [33:0] e);
    rq.push_back(e);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    rry <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    while (done !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk("done", n < 200, 1);
  endtask
  ////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (lv === 1'b1) chk("lpm", {lcfg, ldat}, lq.pop_front());
    if (rv === 1'b1 && rry) chk("axi_rd", {rresp, rdat}, rq.pop_front());
  end
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    close_out();
  end
  initial begin
    {rst_n, por_n, tick, awv, wv, bry, arv, rry} = 8'h00;
    {awa, ara, fdat, tdiv, wd, ws} = '0;
    mismatches = 0;
    total_checks = 0;
    void'($urandom(32'h9f11));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    @(posedge clk);
    axr(flk_pkg::OFS_CTRL, {flk_pkg::RESP_OKAY, 32'h0});
    axr(flk_pkg::OFS_LOCK, {flk_pkg::RESP_OKAY, 32'hff});
    axr(8'h18, {flk_pkg::RESP_SLVERR, 32'h0});
    flo = 8'($urandom);
    fhi = 8'($urandom);
    fex = 4'($urandom);
    axw(flk_pkg::OFS_FUSE_LO, {24'h0, flo}, flk_pkg::RESP_OKAY);
    axw(flk_pkg::OFS_FUSE_HI, {24'h0, fhi}, flk_pkg::RESP_OKAY);
    axw(flk_pkg::OFS_FUSE_EX, {28'h0, fex}, flk_pkg::RESP_OKAY);
    axr(flk_pkg::OFS_FUSE_EX, {flk_pkg::RESP_OKAY, 28'h0, fex});
    // Write without the low byte strobe leaves the fuse alone
    axw(flk_pkg::OFS_FUSE_LO, {24'h0, ~flo}, flk_pkg::RESP_OKAY, 4'h0);
    axr(flk_pkg::OFS_FUSE_LO, {flk_pkg::RESP_OKAY, 24'h0, flo});
    // Each configuration byte, load at window positions 1..3
    cfg = '{~flo, flk_pkg::LOCK_RST, {flk_pkg::FUSE_EX_UNDEF, ~fex}, ~fhi};
    for (int i = 0; i < 4; i++) begin
      lq.push_back({1'b1, cfg[i]});
      u_cpu.ctrl_wr(8'h09);
      u_cpu.idle(i % 3);
      u_cpu.load(16'(i));
    end
    // Plain loads: enable alone, then one cycle past the window
    t = 8'($urandom);
    fdat <= t;
    lq.push_back({1'b0, t});
    lq.push_back({1'b0, t});
    u_cpu.ctrl_wr(8'h01);
    u_cpu.load(16'h0000);
    u_cpu.ctrl_wr(8'h09);
    u_cpu.idle(3);
    u_cpu.load(16'h0000);
    u_cpu.ctrl_wr(8'h09);
    u_cpu.idle(6);
    chk("ctrl", ctrl, 8'h00);
    // Boot lock write from working register zero
    u_cpu.ctrl_wr(8'h09);
    u_cpu.store(16'h0001, 8'hc3);
    @(posedge clk);
    chk("busy", busy, 1'b1);
    wait_done();
    u_cpu.idle(2);
    axr(flk_pkg::OFS_LOCK, {flk_pkg::RESP_OKAY, 32'hc3});
    axr(flk_pkg::OFS_STATUS, {flk_pkg::RESP_OKAY, 32'h4});
    // Erase inside the locked boot section is refused
    u_cpu.ctrl_wr(8'h03);
    u_cpu.store({flk_pkg::BOOT_START_WORD, 1'b0}, 8'h00);
    u_cpu.idle(2);
    chk("busy", busy, 1'b0);
    axr(flk_pkg::OFS_STATUS, {flk_pkg::RESP_OKAY, 32'h6});
    axw(flk_pkg::OFS_STATUS, 32'h2, flk_pkg::RESP_OKAY);
    axr(flk_pkg::OFS_STATUS, {flk_pkg::RESP_OKAY, 32'h4});
    // Page write runs on through a CPU reset
    u_cpu.ctrl_wr(8'h05);
    u_cpu.store(16'h0000, 8'h00);
    u_cpu.idle(4);
    rst_n <= 1'b0;
    u_cpu.idle(2);
    rst_n <= 1'b1;
    wait_done();
    @(posedge clk);
    chk("busy", busy, 1'b0);
    close_out();
  end
endmodule
